// ### rtl/rlas_dup_filter.sv
// Repeat detection on packet identifier and checksum
`timescale 1ns/10ps
module rlas_dup_filter (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic store,
    // Incoming packet
    input wire logic [1:0] packetIdent,
    input wire logic [15:0] crc,
    output logic isRepeat
);
    logic valid_q;
    logic [1:0] ident_q;
    logic [15:0] crc_q;

    assign isRepeat = valid_q && (ident_q == packetIdent) && (crc_q == crc);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
            ident_q <= 2'h0;
            crc_q <= 16'h0000;
        end else if (store) begin
            valid_q <= 1'b1;
            ident_q <= packetIdent;
            crc_q <= crc;
        end else if (clear) begin
            valid_q <= 1'b0;
        end
    end
endmodule : rlas_dup_filter

// ### rtl/rlas_link_seq.sv
// Link automation sequencer: auto resend, auto acknowledge, wake cycles
// Summary of operation
// - Link automation runs only with the simple single-packet buffer mode selected.
// - Transmit strobe starts resend, receive strobe starts acknowledge, sleep ends it.
// - Acknowledge packets carry framing only, no payload.
// - Resend sends the buffer, then switches to receive awaiting acknowledgement.
// - Acknowledge window lasts low eight bits of window field plus one, times 250 us.
// - Good acknowledgement in window returns to sleep, or to idle in auto mode, and signals transmit done.
// - No acknowledgement and count below limit plus one resends and counts.
// - Slave keeps last identifier and checksum; a match marks a repeat.
// - New good packet signals receive done and sends an acknowledgement.
// - Repeated good packet is acknowledged without receive done.
// - Bad checksum or address gives no signal and reception restarts.
// - Device waits the window gap before restarting reception.
// - Wake timer ticks from internal or external low clock by select bit.
// - Single timer mode restarts on each idle entry, stops on sleep.
// - Continuous mode starts on idle, runs until enable or mode clears.
// - In auto mode only idle, sleep, bank and register access are taken.
// - Function 00 wakes periodically and transmits; idle starts, sleep stops.
// - At expiry reload the period, then leave idle one cycle later.
// - After the periodic transmit return to idle until next expiry.
// - With resend, periodic transmit repeats up to limit plus one with windows.
// - Function 01 wakes and listens window plus one units, else back to idle.
// - Sync detection reloads the window with extend field plus one units, but listening then lasts until a packet ends.
// - Good wake-receive packet signals receive done and stays in sleep.
// - Each resend resets the transmit buffer read pointer to zero.
`timescale 1ns/10ps
`include "rlas_params.svh"
module rlas_link_seq #(
    parameter int UNIT_CYCLES = `RLAS_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    // Low-frequency ticks
    input wire logic internal_low_osc,
    input wire logic external_low_clock_in,
    // Radio side
    input wire rlas_pkg::rlas_rx_t rxReport,
    input wire logic txDone,
    input wire logic syncDetect,
    output rlas_pkg::rlas_tx_t txRequest,
    output logic rxEnable,
    // Completion events
    output logic txCompleteIrq,
    output logic rxCompleteIrq
);
    // ==========================================
    // Declarations
    rlas_pkg::rlas_state_t state_q;
    rlas_pkg::rlas_state_t state_d;
    logic [6:0] ctrl_q;
    logic [3:0] resend_limit_q;
    logic [10:0] ack_window_period_q;
    logic [15:0] wake_period_q;
    logic [15:0] listen_extend_period_q;
    logic [7:0] bank_q;
    logic [4:0] resendCnt_q;
    logic [11:0] unitCnt_q;
    logic [16:0] winCnt_q;
    logic unitTick;
    logic winExpire;
    logic syncSeen_q;
    logic timerRun_q;
    logic wakeExpire;
    logic isRepeat;
    logic link_auto_enable;
    logic auto_cycle_enable;
    logic [1:0] auto_cycle_function;
    logic wake_timer_mode;
    logic simpleMode;
    logic arkOn;
    logic autoMode;
    logic cmdWrite;
    logic cmdSleep;
    logic cmdIdle;
    logic cmdTx;
    logic cmdRx;
    logic rxGood;
    logic enterIdle;
    logic txStart;
    logic ackStart;
    logic retry;
    logic winLoad;
    logic [16:0] winLoadVal;

    if (UNIT_CYCLES < 1 || UNIT_CYCLES > 4095) begin : g_unit_check
        $error("unit count out of range");
    end

    // ==========================================
    // Control fields
    assign link_auto_enable = ctrl_q[`RLAS_CTRL_LINK_EN];
    assign auto_cycle_enable = ctrl_q[`RLAS_CTRL_CYC_EN];
    assign auto_cycle_function = ctrl_q[`RLAS_CTRL_FUNC_HI:`RLAS_CTRL_FUNC_LO];
    assign wake_timer_mode = ctrl_q[`RLAS_CTRL_TMODE];
    assign simpleMode = ctrl_q[`RLAS_CTRL_SIMPLE];
    assign arkOn = link_auto_enable && simpleMode;
    assign autoMode = auto_cycle_enable && simpleMode;

    // ==========================================
    // Strobe decode
    assign cmdWrite = regWrite && (regAddr == `RLAS_OFS_CMD);
    assign cmdSleep = cmdWrite && (regWdata[7:0] == `RLAS_CMD_SLEEP);
    assign cmdIdle = cmdWrite && (regWdata[7:0] == `RLAS_CMD_IDLE) && autoMode;
    assign cmdTx = cmdWrite && (regWdata[7:0] == `RLAS_CMD_TX) && !autoMode;
    assign cmdRx = cmdWrite && (regWdata[7:0] == `RLAS_CMD_RX) && !autoMode;

    assign rxGood = rxReport.done && rxReport.crcOk && rxReport.addrOk;

    // ==========================================
    // Register writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `RLAS_CTRL_RESET;
            resend_limit_q <= 4'h0;
            ack_window_period_q <= 11'h000;
            wake_period_q <= 16'h0000;
            listen_extend_period_q <= 16'h0000;
            bank_q <= 8'h00;
        end else if (regWrite) begin
            if (regAddr == `RLAS_OFS_CTRL) begin
                ctrl_q <= regWdata[6:0];
            end else if (regAddr == `RLAS_OFS_RESEND) begin
                resend_limit_q <= regWdata[3:0];
            end else if (regAddr == `RLAS_OFS_WINDOW) begin
                ack_window_period_q <= regWdata[10:0];
            end else if (regAddr == `RLAS_OFS_PERIOD) begin
                wake_period_q <= regWdata;
            end else if (regAddr == `RLAS_OFS_EXTEND) begin
                listen_extend_period_q <= regWdata;
            end else if (regAddr == `RLAS_OFS_BANK) begin
                bank_q <= regWdata[7:0];
            end
        end
    end

    // ==========================================
    // Register reads
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (regRead) begin
            if (regAddr == `RLAS_OFS_CTRL) begin
                regRdata <= {9'h000, ctrl_q};
            end else if (regAddr == `RLAS_OFS_RESEND) begin
                regRdata <= {12'h000, resend_limit_q};
            end else if (regAddr == `RLAS_OFS_WINDOW) begin
                regRdata <= {5'h00, ack_window_period_q};
            end else if (regAddr == `RLAS_OFS_PERIOD) begin
                regRdata <= wake_period_q;
            end else if (regAddr == `RLAS_OFS_EXTEND) begin
                regRdata <= listen_extend_period_q;
            end else if (regAddr == `RLAS_OFS_STATUS) begin
                regRdata <= {3'h0, resendCnt_q, state_q};
            end else if (regAddr == `RLAS_OFS_BANK) begin
                regRdata <= {8'h00, bank_q};
            end else begin
                regRdata <= 16'h0000;
            end
        end else begin
            regRdata <= 16'h0000;
        end
    end

    // ==========================================
    // Time unit and window counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            unitCnt_q <= 12'h000;
        end else if (winLoad || unitCnt_q == 12'(UNIT_CYCLES - 1)) begin
            unitCnt_q <= 12'h000;
        end else begin
            unitCnt_q <= unitCnt_q + 12'h001;
        end
    end
    assign unitTick = (unitCnt_q == 12'(UNIT_CYCLES - 1));

    // window of field plus one units
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            winCnt_q <= 17'h00000;
        end else if (winLoad) begin
            winCnt_q <= winLoadVal;
        end else if (unitTick && winCnt_q != 17'h00000) begin
            winCnt_q <= winCnt_q - 17'h00001;
        end
    end
    assign winExpire = unitTick && (winCnt_q == 17'h00001);

    // ==========================================
    // Wake timer control
    assign enterIdle = (state_d == rlas_pkg::ST_IDLE) && (state_q != rlas_pkg::ST_IDLE);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timerRun_q <= 1'b0;
        end else if (!autoMode || cmdSleep && !wake_timer_mode) begin
            timerRun_q <= 1'b0;
        end else if (wake_timer_mode && regWrite && regAddr == `RLAS_OFS_CTRL
                && !regWdata[`RLAS_CTRL_TMODE]) begin
            timerRun_q <= 1'b0;
        end else if (cmdIdle) begin
            timerRun_q <= 1'b1;
        end
    end

    rlas_wake_timer #(
        .WIDTH(16)
    ) u_wake_timer (
        .clock(clock),
        .rst_n(rst_n),
        .intTick(internal_low_osc),
        .extTick(external_low_clock_in),
        .clkSel(ctrl_q[`RLAS_CTRL_CLKSEL]),
        .load(!wake_timer_mode && enterIdle || cmdIdle && !timerRun_q),
        .run(timerRun_q && (wake_timer_mode || state_q == rlas_pkg::ST_IDLE)),
        .period(wake_period_q),
        .expire(wakeExpire)
    );

    rlas_dup_filter u_dup_filter (
        .clock(clock),
        .rst_n(rst_n),
        .clear(cmdRx),
        .store(state_q == rlas_pkg::ST_LISTEN && rxGood),
        .packetIdent(rxReport.packetIdent),
        .crc(rxReport.crc),
        .isRepeat(isRepeat)
    );

    // ==========================================
    // Sequencer next state
    assign retry = {1'b0, resendCnt_q} < {2'b00, resend_limit_q} + 6'h01;
    always_comb begin
        state_d = state_q;
        txStart = 1'b0;
        ackStart = 1'b0;
        winLoad = 1'b0;
        winLoadVal = {6'h00, ack_window_period_q[7:0]} + 17'h00001;
        case (state_q)
            rlas_pkg::ST_SLEEP: begin
                if (cmdTx) begin
                    state_d = rlas_pkg::ST_TX;
                    txStart = 1'b1;
                end else if (cmdRx) begin
                    state_d = rlas_pkg::ST_LISTEN;
                end else if (cmdIdle) begin
                    state_d = rlas_pkg::ST_IDLE;
                end
            end
            rlas_pkg::ST_TX: begin
                if (txDone && arkOn) begin
                    state_d = rlas_pkg::ST_ACKWAIT;
                    winLoad = 1'b1;
                end else if (txDone) begin
                    state_d = autoMode ? rlas_pkg::ST_IDLE : rlas_pkg::ST_SLEEP;
                end
            end
            rlas_pkg::ST_ACKWAIT: begin
                if (rxReport.done && rxReport.crcOk) begin
                    state_d = autoMode ? rlas_pkg::ST_IDLE : rlas_pkg::ST_SLEEP;
                end else if (winExpire && retry) begin
                    state_d = rlas_pkg::ST_TX;
                    txStart = 1'b1;
                end else if (winExpire) begin
                    state_d = autoMode ? rlas_pkg::ST_IDLE : rlas_pkg::ST_SLEEP;
                end
            end
            rlas_pkg::ST_LISTEN: begin
                if (rxGood && arkOn) begin
                    state_d = rlas_pkg::ST_ACKTX;
                    ackStart = 1'b1;
                end else if (rxGood) begin
                    state_d = rlas_pkg::ST_SLEEP;
                end else if (rxReport.done) begin
                    state_d = rlas_pkg::ST_GAP;
                    winLoad = 1'b1;
                end
            end
            rlas_pkg::ST_ACKTX: begin
                if (txDone) begin
                    state_d = rlas_pkg::ST_GAP;
                    winLoad = 1'b1;
                end
            end
            rlas_pkg::ST_GAP: begin
                if (winExpire) begin
                    state_d = rlas_pkg::ST_LISTEN;
                end
            end
            rlas_pkg::ST_IDLE: begin
                if (wakeExpire && auto_cycle_function == `RLAS_FUNC_WOT) begin
                    state_d = rlas_pkg::ST_TX;
                    txStart = 1'b1;
                end else if (wakeExpire && auto_cycle_function == `RLAS_FUNC_WOR) begin
                    state_d = rlas_pkg::ST_WORRX;
                    winLoad = 1'b1;
                    winLoadVal = {6'h00, ack_window_period_q} + 17'h00001;
                end
            end
            rlas_pkg::ST_WORRX: begin
                if (syncDetect && !syncSeen_q) begin
                    winLoad = 1'b1;
                    winLoadVal = {1'b0, listen_extend_period_q} + 17'h00001;
                end
                if (rxReport.done && rxReport.crcOk) begin
                    state_d = rlas_pkg::ST_SLEEP;
                end else if (winExpire && !syncSeen_q || syncSeen_q && rxReport.done) begin
                    state_d = rlas_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = rlas_pkg::ST_SLEEP;
            end
        endcase
        if (cmdSleep || (!autoMode && state_q == rlas_pkg::ST_IDLE)) begin
            state_d = rlas_pkg::ST_SLEEP;
            txStart = 1'b0;
            ackStart = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= rlas_pkg::ST_SLEEP;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncSeen_q <= 1'b0;
        end else if (state_q != rlas_pkg::ST_WORRX || rxReport.done) begin
            syncSeen_q <= 1'b0;
        end else if (syncDetect) begin
            syncSeen_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resendCnt_q <= 5'h00;
        end else if (cmdTx || state_q == rlas_pkg::ST_IDLE) begin
            resendCnt_q <= 5'h00;
        end else if (state_q == rlas_pkg::ST_ACKWAIT && txStart) begin
            resendCnt_q <= resendCnt_q + 5'h01;
        end
    end

    // ==========================================
    // Radio requests and completion events
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txRequest <= '0;
            txCompleteIrq <= 1'b0;
            rxCompleteIrq <= 1'b0;
        end else begin
            txRequest.start <= txStart || ackStart;
            txRequest.ackOnly <= ackStart;
            txRequest.ptrReset <= txStart;
            txCompleteIrq <= (state_q == rlas_pkg::ST_ACKWAIT && rxReport.done
                && rxReport.crcOk && !cmdSleep)
                || (state_q == rlas_pkg::ST_TX && txDone && !arkOn && !cmdSleep);
            rxCompleteIrq <= !cmdSleep && rxGood && (state_q == rlas_pkg::ST_LISTEN && !isRepeat
                || state_q == rlas_pkg::ST_WORRX);
        end
    end

    assign rxEnable = state_q[2] || state_q[3] || state_q[7];
endmodule : rlas_link_seq

// ### rtl/rlas_params.svh
// Offsets, fields, reset values and timing counts of the link sequencer
`ifndef RLAS_PARAMS_SVH
`define RLAS_PARAMS_SVH
// ==========================================
// Register offsets
`define RLAS_OFS_CTRL 4'h0
`define RLAS_OFS_RESEND 4'h1
`define RLAS_OFS_WINDOW 4'h2
`define RLAS_OFS_PERIOD 4'h3
`define RLAS_OFS_EXTEND 4'h4
`define RLAS_OFS_CMD 4'h5
`define RLAS_OFS_STATUS 4'h6
`define RLAS_OFS_BANK 4'h7
// ==========================================
// Control fields
`define RLAS_CTRL_LINK_EN 0
`define RLAS_CTRL_CYC_EN 1
`define RLAS_CTRL_FUNC_LO 2
`define RLAS_CTRL_FUNC_HI 3
`define RLAS_CTRL_TMODE 4
`define RLAS_CTRL_CLKSEL 5
`define RLAS_CTRL_SIMPLE 6
`define RLAS_CTRL_RESET 7'h40
// ==========================================
// Strobe command codes and auto cycle function codes
`define RLAS_CMD_SLEEP 8'h01
`define RLAS_CMD_IDLE 8'h02
`define RLAS_CMD_TX 8'h03
`define RLAS_CMD_RX 8'h04
`define RLAS_FUNC_WOT 2'h0
`define RLAS_FUNC_WOR 2'h1
// ==========================================
// Timing
`define RLAS_UNIT_NS 250000
`define RLAS_CLK_NS 100
`define RLAS_UNIT_CYCLES (`RLAS_UNIT_NS / `RLAS_CLK_NS)
`endif

// ### rtl/rlas_pkg.sv
// Types shared by the link sequencer modules
package rlas_pkg;
    // ==========================================
    // Sequencer states
    typedef enum logic [7:0] {
        ST_SLEEP = 8'h01,
        ST_TX = 8'h02,
        ST_ACKWAIT = 8'h04,
        ST_LISTEN = 8'h08,
        ST_ACKTX = 8'h10,
        ST_GAP = 8'h20,
        ST_IDLE = 8'h40,
        ST_WORRX = 8'h80
    } rlas_state_t;
    // ==========================================
    // Receiver report
    typedef struct packed {
        logic done;
        logic crcOk;
        logic addrOk;
        logic [1:0] packetIdent;
        logic [15:0] crc;
    } rlas_rx_t;
    // ==========================================
    // Transmit request to the radio
    typedef struct packed {
        logic start;
        logic ackOnly;
        logic ptrReset;
    } rlas_tx_t;
endpackage : rlas_pkg

// ### rtl/rlas_wake_timer.sv
// Low-frequency wake cycle timer with reload
`timescale 1ns/10ps
module rlas_wake_timer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Low-frequency ticks
    input wire logic intTick,
    input wire logic extTick,
    input wire logic clkSel,
    // Control
    input wire logic load,
    input wire logic run,
    input wire logic [WIDTH-1:0] period,
    output logic expire
);
    logic [WIDTH-1:0] count_q;
    logic tick;

    if (WIDTH < 2) begin : g_width_check
        $error("wake timer width too small");
    end

    assign tick = clkSel ? extTick : intTick;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (load) begin
                count_q <= period;
            end else if (run && tick) begin
                if (count_q == '0) begin
                    count_q <= period;
                    expire <= 1'b1;
                end else begin
                    count_q <= count_q - 1'b1;
                end
            end
        end
    end
endmodule : rlas_wake_timer

// ### testbench/rlas_link_seq_assertions.sv
// Port-level checks of the link sequencer
`timescale 1ns/10ps
`include "rlas_params.svh"
module rlas_link_seq_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    // Radio side
    input wire rlas_pkg::rlas_rx_t rxReport,
    input wire logic txDone,
    input wire rlas_pkg::rlas_tx_t txRequest,
    input wire logic rxEnable,
    // Events
    input wire logic txCompleteIrq,
    input wire logic rxCompleteIrq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Properties
    AST_ACK_FRAME: assert property (txRequest.ackOnly |-> txRequest.start)
        else $error("ack frame without start");
    AST_PTR_RESET: assert property (txRequest.start && !txRequest.ackOnly |-> txRequest.ptrReset)
        else $error("resend without pointer reset");
    AST_TX_NO_RX: assert property (txRequest.start |-> !rxEnable)
        else $error("receiver on while sending");
    AST_TXIRQ_SLEEP: assert property (txCompleteIrq |-> !rxEnable && !txRequest.start)
        else $error("not asleep at tx done");
    AST_TXIRQ_CAUSE: assert property (txCompleteIrq |-> $past(txDone || rxReport.done && rxReport.crcOk))
        else $error("tx done without cause");
    AST_RXIRQ_CAUSE: assert property (rxCompleteIrq |-> $past(rxReport.done && rxReport.crcOk && rxReport.addrOk))
        else $error("rx done without good packet");
    AST_BAD_QUIET: assert property (rxReport.done && !(rxReport.crcOk && rxReport.addrOk) |=> !rxCompleteIrq && !txRequest.ackOnly)
        else $error("bad packet answered");
    AST_SLEEP_STOPS: assert property (regWrite && regAddr == `RLAS_OFS_CMD && regWdata[7:0] == `RLAS_CMD_SLEEP |=> !rxEnable && !txRequest.start)
        else $error("sleep command ignored");
endmodule : rlas_link_seq_assertions
bind rlas_link_seq rlas_link_seq_assertions u_rlas_link_seq_assertions (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .rxReport(rxReport),
    .txDone(txDone), .txRequest(txRequest), .rxEnable(rxEnable),
    .txCompleteIrq(txCompleteIrq), .rxCompleteIrq(rxCompleteIrq));

// ### testbench/rlas_radio_model.sv
// Behavioural remote radio
`timescale 1ns/10ps
module rlas_radio_model (
    // Clock
    input wire logic clock,
    // Device side
    input wire rlas_pkg::rlas_tx_t txRequest,
    input wire logic rxEnable,
    output logic txDone,
    output rlas_pkg::rlas_rx_t rxReport,
    // Bench side
    input wire logic ackOn,
    input wire logic fire,
    input wire rlas_pkg::rlas_rx_t pkt
);
    int tc = 0;
    int rc = 0;
    logic pend = 1'b0;
    initial txDone = 1'b0;
    initial rxReport = '0;
    always @(posedge clock) begin
        txDone <= (tc == 1);
        tc = txRequest.start ? 3 : (tc > 0 ? tc - 1 : 0);
        rc = rxEnable ? rc + 1 : 0;
        pend = pend | fire;
        if (rc >= 2 && pend || rc == 2 && ackOn) begin
            rxReport <= pend ? pkt : 21'h1c0000;
            pend = 1'b0;
        end else
            rxReport <= {1'b0, ~rxReport[19:0]};
    end
endmodule : rlas_radio_model

// ### testbench/testbench.sv
// Self-checking bench of the link sequencer
`timescale 1ns/10ps
module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdata;
    logic iTick = 1'b0;
    logic eTick = 1'b0;
    logic txDone, rxEnable, txIrq, rxIrq;
    logic ackOn = 1'b0;
    logic fire = 1'b0;
    logic sync = 1'b0;
    rlas_pkg::rlas_rx_t rxReport;
    rlas_pkg::rlas_rx_t pkt = '0;
    rlas_pkg::rlas_tx_t txRequest;
    int mismatches = 0;
    int total_checks = 0;
    int nSt = 0, nAk = 0, nTi = 0, nRi = 0;
    logic [15:0] rv;
    logic [17:0] id;
    always #50 clock = ~clock;
    rlas_link_seq #(.UNIT_CYCLES(4)) u_rlas_link_seq (.clock(clock), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .internal_low_osc(iTick), .external_low_clock_in(eTick),
        .rxReport(rxReport), .txDone(txDone), .syncDetect(sync), .txRequest(txRequest),
        .rxEnable(rxEnable), .txCompleteIrq(txIrq), .rxCompleteIrq(rxIrq));
    rlas_radio_model u_rlas_radio_model (.clock(clock), .txRequest(txRequest),
        .rxEnable(rxEnable), .txDone(txDone), .rxReport(rxReport), .ackOn(ackOn),
        .fire(fire), .pkt(pkt));
    always @(posedge clock) begin
        iTick <= ($urandom % 8) == 0;
        eTick <= ($urandom % 8) == 0;
        nSt += (txRequest.start === 1'b1);
        nAk += (txRequest.ackOnly === 1'b1);
        nTi += (txIrq === 1'b1);
        nRi += (rxIrq === 1'b1);
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic cmp(input int s, input int a, input int t, input int r);
        check(16'(nSt), 16'(s));
        check(16'(nAk), 16'(a));
        check(16'(nTi), 16'(t));
        check(16'(nRi), 16'(r));
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 rv = regRdata;
    endtask : rd
    task automatic waitSleep();
        for (int i = 0; i < 300; i++) begin
            rd(4'h6);
            if (rv[7:0] === 8'h01)
                return;
        end
        mismatches++;
        print_verdict();
    endtask : waitSleep
    task automatic waitRx(input logic v);
        for (int i = 0; i < 300; i++) begin
            @(posedge clock);
            if (rxEnable === v)
                return;
        end
        mismatches++;
        print_verdict();
    endtask : waitRx
    task automatic waitStart();
        for (int i = 0; i < 300; i++) begin
            @(posedge clock);
            if (txRequest.start === 1'b1)
                return;
        end
        mismatches++;
        print_verdict();
    endtask : waitStart
    task automatic sendPkt(input logic ok, input logic [17:0] packet_ident);
        waitRx(1'b1);
        pkt <= {1'b1, ok, 1'b1, packet_ident};
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        waitRx(1'b0);
        waitRx(1'b1);
    endtask : sendPkt
    initial begin
        void'($urandom(32'h1a7941ca));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(4'h0);
        check(rv, 16'h0040);
        rd(4'hf);
        check(rv, 16'h0000);
        wr(4'h1, 16'h0001);
        wr(4'h2, 16'h0001);
        wr(4'h0, 16'h0041);
        ackOn <= 1'b1;
        wr(4'h5, 16'h0003);
        waitSleep();
        cmp(1, 0, 1, 0);
        ackOn <= 1'b0;
        wr(4'h1, 16'h0002);
        wr(4'h5, 16'h0003);
        waitSleep();
        cmp(5, 0, 1, 0);
        wr(4'h0, 16'h0042);
        wr(4'h5, 16'h0003);
        rd(4'h6);
        check({8'h00, rv[7:0]}, 16'h0001);
        wr(4'h0, 16'h0041);
        wr(4'h5, 16'h0004);
        id = 18'($urandom);
        sendPkt(1'b1, id);
        sendPkt(1'b1, id);
        sendPkt(1'b0, id ^ 18'h00001);
        wr(4'h5, 16'h0001);
        waitSleep();
        cmp(7, 2, 1, 1);
        // Wake-on-transmit cycle
        wr(4'h3, 16'h0008);
        wr(4'h0, 16'h0042);
        wr(4'h5, 16'h0002);
        rd(4'h6);
        check({8'h00, rv[7:0]}, 16'h0040);
        waitStart();
        repeat (6) @(posedge clock);
        rd(4'h6);
        check({8'h00, rv[7:0]}, 16'h0040);
        wr(4'h5, 16'h0001);
        waitSleep();
        cmp(8, 2, 2, 1);
        // Wake-on-receive cycle
        wr(4'h0, 16'h0046);
        wr(4'h5, 16'h0002);
        waitRx(1'b1);
        waitRx(1'b0);
        rd(4'h6);
        check({8'h00, rv[7:0]}, 16'h0040);
        waitRx(1'b1);
        sync <= 1'b1;
        pkt <= {3'h7, id};
        fire <= 1'b1;
        @(posedge clock);
        sync <= 1'b0;
        fire <= 1'b0;
        waitSleep();
        cmp(8, 2, 2, 2);
        print_verdict();
    end
endmodule : testbench
